// *** hdl/acc_pkg.sv ***
package acc_pkg;

  // Register indices as printed; the byte address is four times the index.
  localparam logic [7:0] ACC_IDX_CTRL_STATUS  = 8'h50;
  localparam logic [7:0] ACC_IDX_CONV_CTRL_B  = 8'h7b;
  localparam logic [7:0] ACC_IDX_PIN_IN_OFF   = 8'h7f;
  localparam logic [7:0] ACC_IDX_AUX_CTRL     = 8'h80;
  localparam logic [7:0] ACC_IDX_IRQ_STATUS   = 8'h81;
  localparam logic [7:0] ACC_IDX_IRQ_MASK     = 8'h82;

  // Field positions in the comparator control and status register.
  localparam int ACC_BIT_POWER_OFF      = 7;
  localparam int ACC_BIT_BANDGAP_SEL    = 6;
  localparam int ACC_BIT_OUTPUT         = 5;
  localparam int ACC_BIT_EVENT_FLAG     = 4;
  localparam int ACC_BIT_IRQ_ENABLE     = 3;
  localparam int ACC_BIT_CAPTURE_ROUTE  = 2;
  localparam int ACC_BIT_MODE_HI        = 1;
  localparam int ACC_BIT_MODE_LO        = 0;

  // Field position in converter control register B.
  localparam int ACC_BIT_MUX_NEG_ENABLE = 6;

  // Field positions in the auxiliary control register.
  localparam int ACC_BIT_CONV_ENABLE    = 0;
  localparam int ACC_BIT_CHAN_LO        = 1;
  localparam int ACC_BIT_CHAN_HI        = 3;
  localparam int ACC_BIT_GLOBAL_IRQ     = 4;
  localparam int ACC_BIT_CONV_PWR_RED   = 5;

  // Field position shared by the interrupt status and mask registers.
  localparam int ACC_BIT_IRQ_COMPARE    = 0;

  // Reset values.
  localparam logic [7:0] ACC_RST_CTRL_STATUS = 8'h00;
  localparam logic       ACC_RST_MUX_NEG     = 1'b0;
  localparam logic [1:0] ACC_RST_PIN_IN_OFF  = 2'h0;
  localparam logic [5:0] ACC_RST_AUX_CTRL    = 6'h00;

  // Negative input source code driven to the analog switch; eight means the pin.
  localparam logic [3:0] ACC_NEG_SRC_PIN     = 4'h8;

  // AXI response codes.
  localparam logic [1:0] ACC_RESP_OKAY   = 2'h0;
  localparam logic [1:0] ACC_RESP_SLVERR = 2'h2;

  // Event mode selection.
  typedef enum logic [1:0] {
    ACC_MODE_TOGGLE   = 2'h0,
    ACC_MODE_RESERVED = 2'h1,
    ACC_MODE_FALLING  = 2'h2,
    ACC_MODE_RISING   = 2'h3
  } acc_mode_type;

endpackage

// *** hdl/acc_sync2.sv ***
`timescale 1ns/1ps

// Two-stage synchroniser; the first stage feeds only the second.
module acc_sync2 (
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // Data
  input  wire logic async_in,
  output logic      sync_out
);

  logic meta_q;

  // Both stages reset to zero so the output starts low.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_q   <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule

// *** hdl/acc_top.sv ***
`timescale 1ns/1ps

// Notes on behaviour
// - The raw result is high when the comparator is powered and the chosen positive level is above the chosen negative level, else low.
// - The raw result passes a synchroniser before it shows as the read-only output bit, one to two cycles late.
// - With the mux enable set, the converter off and its power reduction bit clear, channel N feeds the negative input, else the negative pin.
// - The mux enable lives in bit 6 of converter control register B, read-write, reset to zero.
// - The bandgap select bit swaps the positive pin for the internal bandgap level.
// - Writing one to the disable bit powers the comparator off, at any time.
// - The event mode picks toggle (0), reserved (1), falling edge (2) or rising edge (3).
// - Hardware sets the event flag in bit 4 when the synchronised output shows the chosen event.
// - The flag clears when its interrupt vector is taken, or when software writes a one to it.
// - The interrupt is requested only while the flag, its enable in bit 3 and the global enable are all one.
// - With the capture route bit 2 set, the output feeds the timer capture front end, else nothing does.
// - A set pin input-off bit kills that pin's digital input and makes its pin-read bit zero.
// - The converter enable bit shows the converter is on and takes its mux from the comparator.
module acc_top #(
  parameter int LEVEL_WIDTH   = 8,
  parameter int ADDR_WIDTH    = 12,
  parameter logic [7:0] BANDGAP_LEVEL = 8'h80
) (
  // Clock and reset
  input  wire logic                        aclk,
  input  wire logic                        aresetn,
  // AXI4-Lite write address
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  input  wire logic [ADDR_WIDTH-1:0]       s_axi_awaddr,
  input  wire logic [2:0]                  s_axi_awprot,
  // AXI4-Lite write data
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  input  wire logic [31:0]                 s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  // AXI4-Lite write response
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  output logic [1:0]                       s_axi_bresp,
  // AXI4-Lite read address
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  input  wire logic [ADDR_WIDTH-1:0]       s_axi_araddr,
  input  wire logic [2:0]                  s_axi_arprot,
  // AXI4-Lite read data
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  output logic [31:0]                      s_axi_rdata,
  output logic [1:0]                       s_axi_rresp,
  // Digitised analog levels
  input  wire logic [LEVEL_WIDTH-1:0]      positive_input_pin,
  input  wire logic [LEVEL_WIDTH-1:0]      negative_input_pin,
  input  wire logic [8*LEVEL_WIDTH-1:0]    converter_channel_pins,
  // Port pin reads of the two comparator pins
  input  wire logic [1:0]                  pin_raw_in,
  output logic [1:0]                       pin_read_out,
  // Interrupt vector acknowledge and request
  input  wire logic                        irq_vector_taken,
  output logic                             irq,
  // Analog and neighbour controls
  output logic                             comparator_power_off,
  output logic                             bandgap_positive_select,
  output logic [3:0]                       negative_source_select,
  output logic [1:0]                       pin_digital_input_off,
  output logic                             converter_power_reduction,
  output logic                             capture_trigger
);

  import acc_pkg::*;

  if (LEVEL_WIDTH < 1 || LEVEL_WIDTH > 8) begin : g_bad_level
    $error("acc_top: LEVEL_WIDTH must lie between 1 and 8");
  end
  if (ADDR_WIDTH < 11) begin : g_bad_addr
    $error("acc_top: ADDR_WIDTH must be at least 11");
  end

  // Register state.
  logic                   power_off_q;
  logic                   bandgap_sel_q;
  logic                   event_flag_q;
  logic                   irq_enable_q;
  logic                   capture_route_q;
  logic [1:0]             mode_q;
  logic                   mux_neg_enable_q;
  logic [1:0]             pin_in_off_q;
  logic                   conv_enable_q;
  logic [2:0]             chan_select_q;
  logic                   global_irq_q;
  logic                   conv_pwr_red_q;

  // Comparator datapath.
  logic [LEVEL_WIDTH-1:0] pos_level;
  logic [LEVEL_WIDTH-1:0] neg_level;
  logic                   use_channel;
  logic                   raw_result;
  logic                   out_sync;
  logic                   out_prev_q;
  logic                   event_hit;

  // Bus slave state.
  logic                   aw_full_q;
  logic                   w_full_q;
  logic [7:0]             aw_index_q;
  logic                   aw_aligned_q;
  logic [7:0]             wdata_q;
  logic                   wlane_q;
  logic                   do_write;
  logic                   wr_ctrl;
  logic                   wr_irq_status;
  logic                   wr_irq_mask;
  logic                   wr_mapped;
  logic                   flag_clear;
  logic [7:0]             ar_index;
  logic                   ar_mapped;
  logic [7:0]             read_byte;

  // Positive side is the pin or the bandgap level.
  assign pos_level = bandgap_sel_q ? BANDGAP_LEVEL[LEVEL_WIDTH-1:0] : positive_input_pin;

  // The converter mux serves the comparator only while the converter is off and not power-gated.
  assign use_channel = mux_neg_enable_q && !conv_enable_q && !conv_pwr_red_q;

  // Negative side is the selected channel or the pin.
  assign neg_level = use_channel ?
                     converter_channel_pins[chan_select_q*LEVEL_WIDTH +: LEVEL_WIDTH] :
                     negative_input_pin;

  // A powered-off comparator is held low so it cannot create events on its own.
  assign raw_result = !power_off_q && (pos_level > neg_level);

  // Synchronise the raw result before anything digital looks at it.
  acc_sync2 u_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .async_in (raw_result),
    .sync_out (out_sync)
  );

  // Previous output sample for edge detection.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_prev_q <= 1'b0;
    end else begin
      out_prev_q <= out_sync;
    end
  end

  // One compare per clock gives at most one event per clock; the reserved mode never fires.
  always_comb begin
    case (acc_mode_type'(mode_q))
      ACC_MODE_TOGGLE:  event_hit = out_sync != out_prev_q;
      ACC_MODE_FALLING: event_hit = out_prev_q && !out_sync;
      ACC_MODE_RISING:  event_hit = !out_prev_q && out_sync;
      default:          event_hit = 1'b0;
    endcase
  end

  // Write decode; only byte lane 0 carries register data.
  assign do_write      = aw_full_q && w_full_q && !s_axi_bvalid;
  assign wr_ctrl       = do_write && aw_aligned_q && wlane_q && (aw_index_q == ACC_IDX_CTRL_STATUS);
  assign wr_irq_status = do_write && aw_aligned_q && wlane_q && (aw_index_q == ACC_IDX_IRQ_STATUS);
  assign wr_irq_mask   = do_write && aw_aligned_q && wlane_q && (aw_index_q == ACC_IDX_IRQ_MASK);
  assign wr_mapped     = aw_aligned_q && (aw_index_q == ACC_IDX_CTRL_STATUS || aw_index_q == ACC_IDX_CONV_CTRL_B ||
                                         aw_index_q == ACC_IDX_PIN_IN_OFF || aw_index_q == ACC_IDX_AUX_CTRL ||
                                         aw_index_q == ACC_IDX_IRQ_STATUS || aw_index_q == ACC_IDX_IRQ_MASK);

  // A one written to the flag in either view clears it, as does taking the vector.
  assign flag_clear = (wr_ctrl && wdata_q[ACC_BIT_EVENT_FLAG]) ||
                      (wr_irq_status && wdata_q[ACC_BIT_IRQ_COMPARE]) ||
                      irq_vector_taken;

  // Event flag; a new event in the clearing cycle wins so no event is lost.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      event_flag_q <= ACC_RST_CTRL_STATUS[ACC_BIT_EVENT_FLAG];
    end else if (event_hit) begin
      event_flag_q <= 1'b1;
    end else if (flag_clear) begin
      event_flag_q <= 1'b0;
    end
  end

  // Comparator control fields; the mode and disable bits change without guard, software masks first.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      power_off_q     <= ACC_RST_CTRL_STATUS[ACC_BIT_POWER_OFF];
      bandgap_sel_q   <= ACC_RST_CTRL_STATUS[ACC_BIT_BANDGAP_SEL];
      irq_enable_q    <= ACC_RST_CTRL_STATUS[ACC_BIT_IRQ_ENABLE];
      capture_route_q <= ACC_RST_CTRL_STATUS[ACC_BIT_CAPTURE_ROUTE];
      mode_q          <= ACC_RST_CTRL_STATUS[ACC_BIT_MODE_HI:ACC_BIT_MODE_LO];
    end else if (wr_ctrl) begin
      power_off_q     <= wdata_q[ACC_BIT_POWER_OFF];
      bandgap_sel_q   <= wdata_q[ACC_BIT_BANDGAP_SEL];
      irq_enable_q    <= wdata_q[ACC_BIT_IRQ_ENABLE];
      capture_route_q <= wdata_q[ACC_BIT_CAPTURE_ROUTE];
      mode_q          <= wdata_q[ACC_BIT_MODE_HI:ACC_BIT_MODE_LO];
    end else if (wr_irq_mask) begin
      irq_enable_q    <= wdata_q[ACC_BIT_IRQ_COMPARE];
    end
  end

  // Mux enable in converter control register B; other bits of it belong to the converter.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mux_neg_enable_q <= ACC_RST_MUX_NEG;
    end else if (do_write && aw_aligned_q && wlane_q && aw_index_q == ACC_IDX_CONV_CTRL_B) begin
      mux_neg_enable_q <= wdata_q[ACC_BIT_MUX_NEG_ENABLE];
    end
  end

  // Pin digital input disables.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_in_off_q <= ACC_RST_PIN_IN_OFF;
    end else if (do_write && aw_aligned_q && wlane_q && aw_index_q == ACC_IDX_PIN_IN_OFF) begin
      pin_in_off_q <= wdata_q[1:0];
    end
  end

  // Neighbour bits that steer the mux and the interrupt gate.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      conv_enable_q  <= ACC_RST_AUX_CTRL[ACC_BIT_CONV_ENABLE];
      chan_select_q  <= ACC_RST_AUX_CTRL[ACC_BIT_CHAN_HI:ACC_BIT_CHAN_LO];
      global_irq_q   <= ACC_RST_AUX_CTRL[ACC_BIT_GLOBAL_IRQ];
      conv_pwr_red_q <= ACC_RST_AUX_CTRL[ACC_BIT_CONV_PWR_RED];
    end else if (do_write && aw_aligned_q && wlane_q && aw_index_q == ACC_IDX_AUX_CTRL) begin
      conv_enable_q  <= wdata_q[ACC_BIT_CONV_ENABLE];
      chan_select_q  <= wdata_q[ACC_BIT_CHAN_HI:ACC_BIT_CHAN_LO];
      global_irq_q   <= wdata_q[ACC_BIT_GLOBAL_IRQ];
      conv_pwr_red_q <= wdata_q[ACC_BIT_CONV_PWR_RED];
    end
  end

  // Registered outputs toward the analog block, the timer and the port.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq                       <= 1'b0;
      comparator_power_off      <= 1'b0;
      bandgap_positive_select   <= 1'b0;
      negative_source_select    <= ACC_NEG_SRC_PIN;
      pin_digital_input_off     <= 2'h0;
      converter_power_reduction <= 1'b0;
      capture_trigger           <= 1'b0;
      pin_read_out              <= 2'h0;
    end else begin
      irq                       <= event_flag_q && irq_enable_q && global_irq_q;
      comparator_power_off      <= power_off_q;
      bandgap_positive_select   <= bandgap_sel_q;
      negative_source_select    <= use_channel ? {1'b0, chan_select_q} : ACC_NEG_SRC_PIN;
      pin_digital_input_off     <= pin_in_off_q;
      converter_power_reduction <= conv_pwr_red_q;
      capture_trigger           <= capture_route_q && out_sync;
      pin_read_out              <= pin_raw_in & ~pin_in_off_q;
    end
  end

  // Write address and data are taken in either order and held until the response is accepted.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q     <= 1'b0;
      aw_index_q    <= 8'h00;
      aw_aligned_q  <= 1'b0;
      s_axi_awready <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_full_q     <= 1'b1;
      aw_index_q    <= s_axi_awaddr[9:2];
      aw_aligned_q  <= (s_axi_awaddr[1:0] == 2'h0) && (s_axi_awaddr[ADDR_WIDTH-1:10] == '0);
      s_axi_awready <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      aw_full_q     <= 1'b0;
      s_axi_awready <= 1'b1;
    end else if (!aw_full_q) begin
      s_axi_awready <= 1'b1;
    end
  end

  // Write data capture.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_full_q     <= 1'b0;
      wdata_q      <= 8'h00;
      wlane_q      <= 1'b0;
      s_axi_wready <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_full_q     <= 1'b1;
      wdata_q      <= s_axi_wdata[7:0];
      wlane_q      <= s_axi_wstrb[0];
      s_axi_wready <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      w_full_q     <= 1'b0;
      s_axi_wready <= 1'b1;
    end else if (!w_full_q) begin
      s_axi_wready <= 1'b1;
    end
  end

  // Write response one cycle after both halves are held; unmapped addresses answer SLVERR.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= ACC_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_mapped ? ACC_RESP_OKAY : ACC_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read decode; reserved bits read as zero and reads have no side effects.
  assign ar_index  = s_axi_araddr[9:2];
  assign ar_mapped = (s_axi_araddr[1:0] == 2'h0) && (s_axi_araddr[ADDR_WIDTH-1:10] == '0);

  always_comb begin
    read_byte = 8'h00;
    if (ar_mapped) begin
      case (ar_index)
        ACC_IDX_CTRL_STATUS: read_byte = {power_off_q, bandgap_sel_q, out_sync, event_flag_q,
                                          irq_enable_q, capture_route_q, mode_q};
        ACC_IDX_CONV_CTRL_B: read_byte = {1'b0, mux_neg_enable_q, 6'h00};
        ACC_IDX_PIN_IN_OFF:  read_byte = {6'h00, pin_in_off_q};
        ACC_IDX_AUX_CTRL:    read_byte = {2'h0, conv_pwr_red_q, global_irq_q, chan_select_q, conv_enable_q};
        ACC_IDX_IRQ_STATUS:  read_byte = {7'h00, event_flag_q};
        ACC_IDX_IRQ_MASK:    read_byte = {7'h00, irq_enable_q};
        default:             read_byte = 8'h00;
      endcase
    end
  end

  // Read channel answers one cycle after the address is taken.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= ACC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= {24'h00_0000, read_byte};
      s_axi_rresp   <= (ar_mapped && (ar_index == ACC_IDX_CTRL_STATUS || ar_index == ACC_IDX_CONV_CTRL_B ||
                        ar_index == ACC_IDX_PIN_IN_OFF || ar_index == ACC_IDX_AUX_CTRL ||
                        ar_index == ACC_IDX_IRQ_STATUS || ar_index == ACC_IDX_IRQ_MASK)) ?
                       ACC_RESP_OKAY : ACC_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end else if (!s_axi_rvalid) begin
      s_axi_arready <= 1'b1;
    end
  end

endmodule

// *** bench/acc_top_chk.sv ***
`timescale 1ns/1ps

// Port-level checks on the block and its register bus.
module acc_top_chk (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Register bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // Pins and controls
  input wire logic [1:0]  pin_read_out,
  input wire logic [1:0]  pin_digital_input_off,
  input wire logic [3:0]  negative_source_select,
  input wire logic        comparator_power_off,
  input wire logic        capture_trigger
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // A response once offered stays put until the master takes it.
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("bresp moved early");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("rdata moved early");
  // Only one transfer per direction may be in flight.
  a_write_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during response");
  a_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken during data");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("late write response");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("late read data");
  // A pin with its input buffer off reads zero.
  a_pin_off_zero: assert property ((pin_digital_input_off & pin_read_out) == 2'h0)
    else $error("disabled pin reads one");
  // The pin code is eight; channel codes stay under eight.
  a_src_legal: assert property (negative_source_select[3] |-> negative_source_select[2:0] == 3'h0)
    else $error("bad source code");
  // The synchroniser needs a few cycles to empty after power is removed.
  a_off_quiet: assert property (comparator_power_off [*4] |-> !capture_trigger)
    else $error("capture with comparator off");

  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
  c_capture: cover property (capture_trigger);
endmodule

bind acc_top acc_top_chk acc_top_chk_inst (.*);

// *** bench/acc_level_src.sv ***
`timescale 1ns/1ps

// Digitised analog levels at the comparator pins and converter channels.
module acc_level_src (
  // Clock
  input wire logic         aclk,
  // Levels asked for by the bench
  input wire logic [7:0]   pos_set,
  input wire logic [7:0]   neg_set,
  input wire logic [63:0]  chan_set,
  // Levels seen by the block
  output logic [7:0]       pos_lvl,
  output logic [7:0]       neg_lvl,
  output logic [63:0]      chan_lvl
);
  // Levels change just after an edge, never on it.
  always @(posedge aclk) begin
    pos_lvl <= pos_set;
    neg_lvl <= neg_set;
    chan_lvl <= chan_set;
  end
endmodule

// *** bench/tb_acc_top.sv ***
`timescale 1ns/1ps

// Self-checking bench: a register-bus master, a level source and random steps.
module tb_acc_top;
  import acc_pkg::*;
  localparam logic [7:0] I_CS = ACC_IDX_CTRL_STATUS;
  localparam logic [7:0] I_AX = ACC_IDX_AUX_CTRL;
  localparam logic [1:0] OK   = ACC_RESP_OKAY;
  logic        aclk, aresetn, awv, wv, bready, arv, rready, vec;
  logic        awready, wready, bvalid, arready, rvalid, irq, pwr_off, bg_sel, pwr_red, cap;
  logic [11:0] awa, ara;
  logic [31:0] wd, rdata;
  logic [1:0]  bresp, rresp, pin_raw, pin_rd, pin_off;
  logic [3:0]  src;
  logic [7:0]  pos_set, neg_set, pos_lvl, neg_lvl, rv, ch;
  logic [63:0] chan_set, chan_lvl, tmp;
  logic [7:0]  tab [6] = '{I_CS, ACC_IDX_CONV_CTRL_B, ACC_IDX_PIN_IN_OFF, I_AX, ACC_IDX_IRQ_STATUS, ACC_IDX_IRQ_MASK};
  int          mismatches, total_checks, cycles;

  // Block under test; protection and strobes are held fixed.
  acc_top acc_top_inst (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(awv), .s_axi_awready(awready), .s_axi_awaddr(awa),
    .s_axi_awprot(3'h0), .s_axi_wvalid(wv), .s_axi_wready(wready), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arv),
    .s_axi_arready(arready), .s_axi_araddr(ara), .s_axi_arprot(3'h0), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .positive_input_pin(pos_lvl),
    .negative_input_pin(neg_lvl), .converter_channel_pins(chan_lvl), .pin_raw_in(pin_raw),
    .pin_read_out(pin_rd), .irq_vector_taken(vec), .irq(irq), .comparator_power_off(pwr_off),
    .bandgap_positive_select(bg_sel), .negative_source_select(src), .pin_digital_input_off(pin_off),
    .converter_power_reduction(pwr_red), .capture_trigger(cap));
  acc_level_src acc_level_src_inst (.aclk(aclk), .pos_set(pos_set), .neg_set(neg_set), .chan_set(chan_set),
    .pos_lvl(pos_lvl), .neg_lvl(neg_lvl), .chan_lvl(chan_lvl));

  initial aclk = 1'h0;
  always #10 aclk = ~aclk;

  // Cut a hang short; the run needs about five hundred cycles.
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      mismatches++;
      print_verdict();
    end
  end

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // Write and read hold each channel until its own handshake edge.
  task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er);
    @(posedge aclk);
    {awv, wv, bready} <= 3'h7;
    awa <= {2'h0, idx, 2'h0};
    wd <= {24'h0, d};
    forever begin
      @(posedge aclk);
      if (awv && awready) awv <= 1'h0;
      if (wv && wready) wv <= 1'h0;
      if (bvalid && bready) begin
        chk("bresp", bresp, er);
        bready <= 1'h0;
        break;
      end
    end
  endtask

  task automatic rd(input logic [7:0] idx, input logic [1:0] er);
    @(posedge aclk);
    {arv, rready} <= 2'h3;
    ara <= {2'h0, idx, 2'h0};
    forever begin
      @(posedge aclk);
      if (arv && arready) arv <= 1'h0;
      if (rvalid && rready) begin
        rv = rdata[7:0];
        chk("rresp", rresp, er);
        chk("rdata_hi", rdata[31:8], 0);
        rready <= 1'h0;
        break;
      end
    end
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // Six cycles cover the level source, the synchroniser, the flag and irq.
  task automatic lv(input logic [7:0] p, input logic [7:0] n);
    @(posedge aclk);
    pos_set <= p;
    neg_set <= n;
    wait_n(6);
  endtask

  function automatic logic flag_exp(input int m, input logic rise);
    return (m == 0) || (m == 3 && rise) || (m == 2 && !rise);
  endfunction

  initial begin
    {awv, wv, bready, arv, rready, vec, pin_raw} = '0;
    {awa, ara, wd, pos_set, neg_set, chan_set, tmp} = '0;
    aresetn = 1'h0;
    void'($urandom(32));
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    foreach (tab[i]) begin
      rd(tab[i], OK);
      chk("reset_value", rv, 8'h00);
    end
    chk("src_reset", src, ACC_NEG_SRC_PIN);
    wr(8'h60, 8'hff, ACC_RESP_SLVERR);
    rd(8'h60, ACC_RESP_SLVERR);
    $display("test reset and map done");
    for (int i = 0; i < 4; i++) begin
      pin_raw <= 2'($urandom);
      wr(ACC_IDX_PIN_IN_OFF, 8'(i), OK);
      wait_n(2);
      rd(ACC_IDX_PIN_IN_OFF, OK);
      chk("pin_off_reg", rv, i);
      chk("pin_off", pin_off, i);
      chk("pin_read", pin_rd, pin_raw & ~2'(i));
    end
    $display("test pin input off done");
    wr(ACC_IDX_CONV_CTRL_B, 8'hff, OK);
    rd(ACC_IDX_CONV_CTRL_B, OK);
    chk("mux_enable", rv[6], 1);
    for (int i = 0; i < 8; i++) begin
      ch = 8'($urandom_range(254, 0));
      tmp = {$urandom, $urandom};
      tmp[i*8+:8] = ch;
      chan_set <= tmp;
      wr(I_AX, 8'(i << 1), OK);
      lv(ch + 8'h1, 8'hff);
      chk("src_chan", src, i);
      rd(I_CS, OK);
      chk("out_chan", rv[5], 1);
      wr(I_AX, 8'(i << 1) | 8'h01, OK);
      wait_n(6);
      chk("src_conv_on", src, ACC_NEG_SRC_PIN);
      rd(I_CS, OK);
      chk("out_pin", rv[5], 0);
    end
    wr(I_AX, 8'h20, OK);
    wait_n(2);
    chk("pwr_red", pwr_red, 1);
    chk("src_reduced", src, ACC_NEG_SRC_PIN);
    wr(I_AX, 8'h00, OK);
    wr(ACC_IDX_CONV_CTRL_B, 8'h00, OK);
    $display("test negative mux done");
    lv(8'd50, 8'd100);
    for (int m = 0; m < 4; m++) begin
      wr(I_CS, 8'h10 | 8'(m), OK);
      lv(8'd200, 8'd100);
      rd(I_CS, OK);
      chk("out_high", rv[5], 1);
      chk("flag_rise", rv[4], flag_exp(m, 1'h1));
      wr(I_CS, 8'h10 | 8'(m), OK);
      lv(8'd50, 8'd100);
      rd(I_CS, OK);
      chk("flag_fall", rv[4], flag_exp(m, 1'h0));
    end
    $display("test event modes done");
    wr(I_CS, 8'h13, OK);
    wr(I_CS, 8'h0b, OK);
    wr(I_AX, 8'h10, OK);
    lv(8'd200, 8'd100);
    chk("irq_set", irq, 1);
    wr(ACC_IDX_IRQ_MASK, 8'h00, OK);
    wait_n(3);
    chk("irq_masked", irq, 0);
    wr(ACC_IDX_IRQ_MASK, 8'h01, OK);
    wait_n(3);
    chk("irq_unmasked", irq, 1);
    wr(I_AX, 8'h00, OK);
    wait_n(3);
    chk("irq_global_off", irq, 0);
    wr(I_AX, 8'h10, OK);
    @(posedge aclk);
    vec <= 1'h1;
    @(posedge aclk);
    vec <= 1'h0;
    wait_n(3);
    chk("irq_vector", irq, 0);
    rd(ACC_IDX_IRQ_STATUS, OK);
    chk("status_vector", rv[0], 0);
    lv(8'd50, 8'd100);
    lv(8'd200, 8'd100);
    chk("irq_again", irq, 1);
    wr(ACC_IDX_IRQ_STATUS, 8'h01, OK);
    wait_n(3);
    chk("irq_w1c", irq, 0);
    wr(I_CS, 8'h13, OK);
    $display("test interrupt done");
    wr(I_CS, 8'h44, OK);
    lv(8'h00, 8'h10);
    chk("bandgap", bg_sel, 1);
    rd(I_CS, OK);
    chk("out_bandgap", rv[5], 1);
    chk("capture_on", cap, 1);
    wr(I_CS, 8'h40, OK);
    wait_n(3);
    chk("capture_off", cap, 0);
    wr(I_CS, 8'hc4, OK);
    wait_n(6);
    chk("power_off", pwr_off, 1);
    rd(I_CS, OK);
    chk("out_off", rv[5], 0);
    chk("capture_pwr_off", cap, 0);
    $display("test bandgap capture power done");
    print_verdict();
  end
endmodule
